// >>> test_access_port.sv
// Functional notes
// [R01] Test clock, sampled here, paces every controller step and serial shift.
// [R02] Mode select is taken on each test clock rise to step the controller.
// [R03] Serial data input is captured on each test clock rise.
// [R04] Serial output is driven only in shift-IR or shift-DR, else released.
// [R05] Serial output changes only on test clock falling edges.
// [R06] Pull-up disable bit set turns off mode select and data input pull-ups.
// [R07] Active-low test reset forces the controller into test-logic-reset at once.
`timescale 1ns/10ps
module test_access_port
  import tap_pkg::*;
#(
  parameter int DRW = DR_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic pull_up_disable,
  output logic pull_up_en,
  output logic word_valid,
  input wire logic word_ready,
  output dr_word_s word_out,
  input wire logic [15:0] capture_data,
  output logic [3:0] tap_state
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic tck_prev;
  logic trst_n_s1;
  logic trst_n_s2;

  // Pins come from the test host's domain, so two flops each first.
  // Reset values match the idle pins (clock low, select and data high),
  // so no false test clock edge is seen when reset lets go.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 3'h3;
      sync2 <= 3'h3;
      tck_prev <= 1'b0;
    end else begin
      sync1 <= {tck, tms, tdi};
      sync2 <= sync1;
      tck_prev <= sync2[2];
    end
  end

  // The test reset is asserted asynchronously and released through two flops.
  always_ff @(posedge clk or posedge sys_rst or negedge trst_n) begin
    if (sys_rst) begin
      trst_n_s1 <= 1'b0;
      trst_n_s2 <= 1'b0;
    end else if (!trst_n) begin
      trst_n_s1 <= 1'b0;
      trst_n_s2 <= 1'b0;
    end else begin
      trst_n_s1 <= 1'b1;
      trst_n_s2 <= trst_n_s1;
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;
  logic tap_rst;

  assign tck_s = sync2[2];
  assign tms_s = sync2[1];
  assign tdi_s = sync2[0];
  assign tck_rise = tck_s && !tck_prev; // see [R01]
  assign tck_fall = !tck_s && tck_prev; // see [R01]
  assign tap_rst = sys_rst || !trst_n;

  // ****************************************************************
  // Controller state machine
  // ****************************************************************
  tap_state_e state;
  tap_state_e next_state;

  always_comb begin
    unique case (state)
      ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms_s ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms_s ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms_s ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms_s ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Test reset wins immediately; it does not wait for a test clock edge.
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      state <= ST_RESET; // see [R07]
    end else if (!trst_n_s2) begin
      state <= ST_RESET; // see [R07]
    end else if (tck_rise) begin
      state <= next_state; // see [R02]
    end
  end

  assign tap_state = state;

  // ****************************************************************
  // Instruction and data shift registers
  // ****************************************************************
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] ir;
  logic [DRW-1:0] dr_shift;
  logic bypass_bit;
  logic is_bypass;
  logic fifo_ready;
  logic push;

  assign is_bypass = (ir == IR_BYPASS);

  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_shift <= '0;
      ir <= IR_RESET;
    end else if (state == ST_RESET) begin
      ir <= IR_RESET;
    end else if (tck_rise) begin
      if (state == ST_CAPTURE_IR) begin
        ir_shift <= IR_CAPTURE;
      end else if (state == ST_SHIFT_IR) begin
        ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]}; // see [R03]
      end else if (state == ST_UPDATE_IR) begin
        ir <= ir_shift;
      end
    end
  end

  // Data path; bypass is a one-bit register as usual.
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      dr_shift <= '0;
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (state == ST_CAPTURE_DR) begin
        dr_shift <= capture_data[DRW-1:0];
        bypass_bit <= 1'b0;
      end else if (state == ST_SHIFT_DR) begin
        dr_shift <= {tdi_s, dr_shift[DRW-1:1]}; // see [R03]
        bypass_bit <= tdi_s; // see [R03]
      end
    end
  end

  // A finished word goes to the core; if the FIFO is full the word is
  // dropped, since the test host cannot be stalled on this link.
  assign push = tck_rise && (state == ST_UPDATE_DR) && !is_bypass;

  word_fifo #(
    .WIDTH(IR_WIDTH + DRW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({ir, dr_shift}),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_out)
  );

  // ****************************************************************
  // Serial output
  // ****************************************************************
  logic shifting;

  assign shifting = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);

  // Output moves only on a falling test clock so the host samples a stable bit.
  always_ff @(posedge clk or posedge tap_rst) begin
    if (tap_rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= shifting; // see [R04]
      if (state == ST_SHIFT_IR) begin
        tdo <= ir_shift[0]; // see [R05]
      end else if (state == ST_SHIFT_DR) begin
        tdo <= is_bypass ? bypass_bit : dr_shift[0]; // see [R05]
      end
    end
  end

  // Pull-ups are a static pad control, no sampling needed.
  assign pull_up_en = !pull_up_disable; // see [R06]

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reset_state: assert property (@(posedge clk) disable iff (sys_rst)
    !trst_n_s2 |=> state == ST_RESET) else $error("reset did not hold TLR"); // see [R07]
  a_tdo_oe_shift: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && !shifting |=> !tdo_oe) else $error("tdo driven outside shift"); // see [R04]
  a_tdo_oe_on: assert property (@(posedge clk) disable iff (tap_rst)
    tck_fall && shifting |=> tdo_oe) else $error("tdo not driven in shift"); // see [R04]
  a_tdo_fall_only: assert property (@(posedge clk) disable iff (tap_rst)
    !tck_fall |=> $stable(tdo)) else $error("tdo changed off falling edge"); // see [R05]
  a_state_step: assert property (@(posedge clk) disable iff (tap_rst)
    trst_n_s2 && !tck_rise |=> $stable(state)) else $error("state moved without edge"); // see [R02]
  a_tms_reset: assert property (@(posedge clk) disable iff (tap_rst)
    trst_n_s2 && tck_rise && tms_s && state == ST_SEL_IR |=> state == ST_RESET)
    else $error("tms high not to TLR"); // see [R02]
  a_tdi_shift: assert property (@(posedge clk) disable iff (tap_rst)
    tck_rise && state == ST_SHIFT_DR |=> dr_shift[DRW-1] == $past(tdi_s))
    else $error("tdi not captured"); // see [R03]
  a_edge_pair: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise |-> !tck_fall) else $error("edge detect conflict"); // see [R01]
  a_pull_up: assert property (@(posedge clk) disable iff (sys_rst)
    pull_up_en != pull_up_disable) else $error("pull-up control wrong"); // see [R06]

endmodule

// >>> tap_pkg.sv
package tap_pkg;

  // ****************************************************************
  // TAP controller states, standard 16-state encoding
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RESET      = 4'hF,
    ST_IDLE       = 4'hC,
    ST_SEL_DR     = 4'h7,
    ST_CAPTURE_DR = 4'h6,
    ST_SHIFT_DR   = 4'h2,
    ST_EXIT1_DR   = 4'h1,
    ST_PAUSE_DR   = 4'h3,
    ST_EXIT2_DR   = 4'h0,
    ST_UPDATE_DR  = 4'h5,
    ST_SEL_IR     = 4'h4,
    ST_CAPTURE_IR = 4'hE,
    ST_SHIFT_IR   = 4'hA,
    ST_EXIT1_IR   = 4'h9,
    ST_PAUSE_IR   = 4'hB,
    ST_EXIT2_IR   = 4'h8,
    ST_UPDATE_IR  = 4'hD
  } tap_state_e;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam int DR_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 2;

  // Completed data-register word handed to the core side.
  typedef struct packed {
    logic [3:0] instr;
    logic [15:0] data;
  } dr_word_s;

endpackage

// >>> word_fifo.sv
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest full and empty come straight from the occupancy count.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// >>> jtag_host.sv
`timescale 1ns/10ps
// ****************************************************************
// Debug host model on the far side of the test port
// ****************************************************************
module jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic tdo_wire;
  // A released output rises on the pad pull-up, so the host then reads 1.
  assign tdo_wire = tdo_oe ? tdo : 1'b1;
  // Test clock stands low between frames; the port starts held in reset.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
  end
  task automatic set_reset(input logic v);
    trst_n = v;
  endtask
  // One test clock period: inputs change while low, output is taken at the rise.
  task automatic step(input logic m, input logic d, output logic q, output logic oe,
                      output logic held);
    tms = m;
    tdi = d;
    #62.5;
    tck = 1'b1;
    q = tdo_wire;
    oe = tdo_oe;
    #62.3;
    held = (tdo_wire === q);
    #0.2;
    tck = 1'b0;
  endtask
  // Full scan from idle back to idle, LSB first.
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout, output logic oe_ok, output logic held_ok);
    logic q, oe, h;
    dout = 16'h0000;
    oe_ok = 1'b1;
    held_ok = 1'b1;
    step(1'b1, 1'b1, q, oe, h);
    if (ir) begin
      step(1'b1, 1'b1, q, oe, h);
    end
    step(1'b0, 1'b1, q, oe, h);
    step(1'b0, 1'b1, q, oe, h);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q, oe, h);
      dout[i] = q;
      oe_ok &= oe;
      held_ok &= h;
    end
    step(1'b1, 1'b1, q, oe, h);
    step(1'b0, 1'b1, q, oe, h);
  endtask
endmodule

// >>> tb.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the test access port
// ****************************************************************
module tb;
  import tap_pkg::*;
  logic clk, sys_rst, pull_up_disable, pull_up_en, word_ready, word_valid;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, oe_ok, held_ok, q, oe, h;
  logic [15:0] capture_data, dout;
  logic [3:0] tap_state;
  dr_word_s word_out;
  int err_total, checks_done, cycles;
  test_access_port u_dut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pull_up_disable(pull_up_disable),
    .pull_up_en(pull_up_en), .word_valid(word_valid), .word_ready(word_ready),
    .word_out(word_out), .capture_data(capture_data), .tap_state(tap_state));
  jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run of about 4800 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic t_pullup();
    for (int v = 0; v < 2; v++) begin
      @(negedge clk) pull_up_disable = v[0];
      #1 check(pull_up_en, !v[0]);
    end
  endtask
  task automatic t_ir(input logic [3:0] instr);
    u_host.scan(1'b1, IR_WIDTH, {12'h000, instr}, dout, oe_ok, held_ok);
    check(dout[3:0], IR_CAPTURE);
    check(held_ok, 1'b1);
    check(oe_ok, 1'b1);
    check(tdo_oe, 1'b0);
    check(tap_state, ST_IDLE);
  endtask
  // Five scans with the consumer stalled, then drain: the fifth is dropped.
  task automatic t_fill();
    for (int k = 0; k < 5; k++) begin
      u_host.scan(1'b0, DR_WIDTH, 16'h1000 + k[15:0], dout, oe_ok, held_ok);
      check(dout, capture_data);
      check(oe_ok, 1'b1);
      check(word_valid, 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk) check(word_out, {4'h5, 16'h1000 + k[15:0]});
      word_ready = 1'b1;
      @(negedge clk) word_ready = 1'b0;
    end
    #1 check(word_valid, 1'b0);
  endtask
  task automatic t_bypass();
    u_host.scan(1'b0, DR_WIDTH, 16'hBEEF, dout, oe_ok, held_ok);
    check(dout[15:1], 15'h3EEF);
    check(word_valid, 1'b0);
  endtask
  // Test reset in mid-shift must drop the controller at once.
  task automatic t_trst();
    u_host.step(1'b1, 1'b1, q, oe, h);
    u_host.step(1'b0, 1'b1, q, oe, h);
    u_host.step(1'b0, 1'b1, q, oe, h);
    u_host.step(1'b0, 1'b1, q, oe, h);
    check(tdo_oe, 1'b1);
    u_host.set_reset(1'b0);
    #3 check(tap_state, ST_RESET);
    check(tdo_oe, 1'b0);
    u_host.set_reset(1'b1);
    #40 u_host.step(1'b0, 1'b1, q, oe, h);
    check(tap_state, ST_IDLE);
  endtask
  initial begin
    sys_rst = 1'b1;
    pull_up_disable = 1'b0;
    word_ready = 1'b0;
    capture_data = 16'hA5C3;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    u_host.set_reset(1'b1);
    repeat (4) @(negedge clk);
    check(tap_state, ST_RESET);
    check(tdo_oe, 1'b0);
    t_pullup();
    #0.7 u_host.step(1'b0, 1'b1, q, oe, h);
    check(tap_state, ST_IDLE);
    t_ir(4'h5);
    t_fill();
    t_ir(IR_BYPASS);
    t_bypass();
    t_trst();
    tally_and_finish();
  end
endmodule
